/* File: dcc_pkg.sv */
package dcc_pkg;

   // register addresses on the special-function register port
   localparam logic [7:0] DCC_ADDR_C0_CTRL_A = 8'h9B;
   localparam logic [7:0] DCC_ADDR_C0_CTRL_B = 8'h99;
   localparam logic [7:0] DCC_ADDR_C0_MODE   = 8'h9D;
   localparam logic [7:0] DCC_ADDR_C0_INSEL  = 8'h9F;
   localparam logic [7:0] DCC_ADDR_C1_CTRL_A = 8'hBF;
   localparam logic [7:0] DCC_ADDR_C1_CTRL_B = 8'hAC;
   localparam logic [7:0] DCC_ADDR_C1_MODE   = 8'hAB;
   localparam logic [7:0] DCC_ADDR_C1_INSEL  = 8'hAA;

   // control a field positions
   localparam int DCC_CA_EN_BIT   = 7;
   localparam int DCC_CA_OUT_BIT  = 6;
   localparam int DCC_CA_RISE_BIT = 5;
   localparam int DCC_CA_FALL_BIT = 4;
   // mode field positions
   localparam int DCC_MD_LATCH_BIT = 7;
   localparam int DCC_MD_INV_BIT   = 6;
   localparam int DCC_MD_RIE_BIT   = 5;
   localparam int DCC_MD_FIE_BIT   = 4;
   // control b field positions
   localparam int DCC_CB_HOLD_BIT = 7;

   // reset values
   localparam logic [7:0] DCC_RST_CTRL_A = 8'h00;
   localparam logic [7:0] DCC_RST_MODE   = 8'h02;
   localparam logic [7:0] DCC_RST_INSEL  = 8'hFF;
   localparam logic [7:0] DCC_RST_CTRL_B = 8'h00;

   // input routing encodings
   typedef enum logic [1:0] {
      DCC_ROUTE_DIRECT  = 2'h0,
      DCC_ROUTE_NEG_GND = 2'h1,
      DCC_ROUTE_DAC_POS = 2'h2,
      DCC_ROUTE_DAC_NEG = 2'h3
   } dcc_route_t;

   // settings presented to one analog core
   typedef struct packed {
      logic       power_enable;
      logic [1:0] pos_hysteresis_sel;
      logic [1:0] neg_hysteresis_sel;
      logic [1:0] response_speed_sel;
      logic [3:0] pos_channel_sel;
      logic [3:0] neg_channel_sel;
      logic       neg_to_gnd;
      logic       dac_enable;
      logic       dac_on_pos;
      logic       dac_fullscale_source;
      logic [5:0] ref_dac_level;
   } dcc_analog_t;

   // register port request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } dcc_sfr_req_t;

endpackage : dcc_pkg

/* File: dcc_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser for the raw analog result
module dcc_sync
(
   input  wire logic mclk,
   input  wire logic rst_n,
   input  wire logic async_in,
   output var  logic sync_out
);
   logic meta_q;

   // first stage is read only by the second
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_q   <= 1'b0;
         sync_out <= 1'b0;
      end
      else
      begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule : dcc_sync
`default_nettype wire

/* File: dcc_channel.sv */
`timescale 1ns/1ps
`default_nettype none
// one comparator control channel, four registers, no shared state
module dcc_channel
   import dcc_pkg::*;
#(
   parameter logic [7:0] ADDR_CA = 8'h9B,
   parameter logic [7:0] ADDR_CB = 8'h99,
   parameter logic [7:0] ADDR_MD = 8'h9D,
   parameter logic [7:0] ADDR_MX = 8'h9F
)
(
   input  wire logic         mclk,
   input  wire logic         rst_n,
   input  wire dcc_sfr_req_t req,
   input  wire logic         raw_result,
   input  wire logic         counter_overflow,
   input  wire logic         counter_channel2_output,
   output var  logic         hit,
   output var  logic [7:0]   rdata,
   output var  logic         result,
   output var  logic         rise_irq,
   output var  logic         fall_irq,
   output var  dcc_analog_t  analog
);
   import dcc_pkg::*;

   logic       sync_res;
   logic       comp_power_enable_q;
   logic       rise_seen_flag_q;
   logic       fall_seen_flag_q;
   logic [1:0] pos_hysteresis_sel_q;
   logic [1:0] neg_hysteresis_sel_q;
   logic       overflow_latched_result_q;
   logic       result_polarity_invert_q;
   logic       rise_irq_enable_q;
   logic       fall_irq_enable_q;
   logic [1:0] input_routing_sel_q;
   logic [1:0] response_speed_sel_q;
   logic [3:0] neg_channel_sel_q;
   logic [3:0] pos_channel_sel_q;
   logic       result_hold_enable_q;
   logic [5:0] ref_dac_level_q;
   logic       result_q;
   logic       result_d;
   logic       prev_q;
   logic       rise_ev;
   logic       fall_ev;
   logic       wr_ca;
   logic       wr_cb;
   logic       wr_md;
   logic       wr_mx;

   dcc_sync u_sync (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .async_in (raw_result),
      .sync_out (sync_res)
   );

   assign wr_ca = req.wr && (req.addr == ADDR_CA);
   assign wr_cb = req.wr && (req.addr == ADDR_CB);
   assign wr_md = req.wr && (req.addr == ADDR_MD);
   assign wr_mx = req.wr && (req.addr == ADDR_MX);

   // module output: off forces low, inversion, hold while channel 2 low
   always_comb
   begin
      if (!comp_power_enable_q)
         result_d = 1'b0;
      else if (result_hold_enable_q && !counter_channel2_output)
         result_d = result_q;
      else
         result_d = sync_res ^ result_polarity_invert_q;
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         result_q <= 1'b0;
         prev_q   <= 1'b0;
      end
      else
      begin
         result_q <= result_d;
         prev_q   <= result_q;
      end
   end

   assign rise_ev = result_q && !prev_q;
   assign fall_ev = !result_q && prev_q;

   // edge flags: only software clears, an edge beats a clear
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rise_seen_flag_q <= 1'b0;
         fall_seen_flag_q <= 1'b0;
      end
      else
      begin
         if (rise_ev)
            rise_seen_flag_q <= 1'b1;
         else if (wr_ca)
            rise_seen_flag_q <= req.wdata[DCC_CA_RISE_BIT];
         if (fall_ev)
            fall_seen_flag_q <= 1'b1;
         else if (wr_ca)
            fall_seen_flag_q <= req.wdata[DCC_CA_FALL_BIT];
      end
   end

   // control a writable fields
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         comp_power_enable_q  <= DCC_RST_CTRL_A[DCC_CA_EN_BIT];
         pos_hysteresis_sel_q <= DCC_RST_CTRL_A[3:2];
         neg_hysteresis_sel_q <= DCC_RST_CTRL_A[1:0];
      end
      else if (wr_ca)
      begin
         comp_power_enable_q  <= req.wdata[DCC_CA_EN_BIT];
         pos_hysteresis_sel_q <= req.wdata[3:2];
         neg_hysteresis_sel_q <= req.wdata[1:0];
      end
   end

   // mode register; latched bit also writable, overflow wins
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         overflow_latched_result_q <= DCC_RST_MODE[DCC_MD_LATCH_BIT];
         result_polarity_invert_q  <= DCC_RST_MODE[DCC_MD_INV_BIT];
         rise_irq_enable_q         <= DCC_RST_MODE[DCC_MD_RIE_BIT];
         fall_irq_enable_q         <= DCC_RST_MODE[DCC_MD_FIE_BIT];
         input_routing_sel_q       <= DCC_RST_MODE[3:2];
         response_speed_sel_q      <= DCC_RST_MODE[1:0];
      end
      else
      begin
         if (counter_overflow)
            overflow_latched_result_q <= result_q;
         else if (wr_md)
            overflow_latched_result_q <= req.wdata[DCC_MD_LATCH_BIT];
         if (wr_md)
         begin
            result_polarity_invert_q <= req.wdata[DCC_MD_INV_BIT];
            rise_irq_enable_q        <= req.wdata[DCC_MD_RIE_BIT];
            fall_irq_enable_q        <= req.wdata[DCC_MD_FIE_BIT];
            input_routing_sel_q      <= req.wdata[3:2];
            response_speed_sel_q     <= req.wdata[1:0];
         end
      end
   end

   // mux select and control b; reserved bit 6 not stored
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         neg_channel_sel_q    <= DCC_RST_INSEL[7:4];
         pos_channel_sel_q    <= DCC_RST_INSEL[3:0];
         result_hold_enable_q <= DCC_RST_CTRL_B[DCC_CB_HOLD_BIT];
         ref_dac_level_q      <= DCC_RST_CTRL_B[5:0];
      end
      else
      begin
         if (wr_mx)
         begin
            neg_channel_sel_q <= req.wdata[7:4];
            pos_channel_sel_q <= req.wdata[3:0];
         end
         if (wr_cb)
         begin
            result_hold_enable_q <= req.wdata[DCC_CB_HOLD_BIT];
            ref_dac_level_q      <= req.wdata[5:0];
         end
      end
   end

   // interrupt requests, registered
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rise_irq <= 1'b0;
         fall_irq <= 1'b0;
      end
      else
      begin
         rise_irq <= rise_irq_enable_q && rise_seen_flag_q;
         fall_irq <= fall_irq_enable_q && fall_seen_flag_q;
      end
   end

   assign result = result_q;

   // analog settings, decoded from the routing field
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         analog <= '0;
      else
      begin
         analog.power_enable       <= comp_power_enable_q;
         analog.pos_hysteresis_sel <= pos_hysteresis_sel_q;
         analog.neg_hysteresis_sel <= neg_hysteresis_sel_q;
         analog.response_speed_sel <= response_speed_sel_q;
         analog.pos_channel_sel    <= pos_channel_sel_q;
         analog.neg_channel_sel    <= neg_channel_sel_q;
         analog.ref_dac_level      <= ref_dac_level_q;
         case (dcc_route_t'(input_routing_sel_q))
            DCC_ROUTE_DIRECT:
            begin
               analog.neg_to_gnd <= 1'b0;
               analog.dac_enable <= 1'b0;
               analog.dac_on_pos <= 1'b0;
               analog.dac_fullscale_source <= 1'b0;
            end
            DCC_ROUTE_NEG_GND:
            begin
               analog.neg_to_gnd <= 1'b1;
               analog.dac_enable <= 1'b0;
               analog.dac_on_pos <= 1'b0;
               analog.dac_fullscale_source <= 1'b0;
            end
            DCC_ROUTE_DAC_POS:
            begin
               analog.neg_to_gnd <= 1'b0;
               analog.dac_enable <= 1'b1;
               analog.dac_on_pos <= 1'b1;
               analog.dac_fullscale_source <= 1'b0;  // positive mux feeds dac
            end
            default:
            begin
               analog.neg_to_gnd <= 1'b0;
               analog.dac_enable <= 1'b1;
               analog.dac_on_pos <= 1'b0;
               analog.dac_fullscale_source <= 1'b1;  // negative mux feeds dac
            end
         endcase
      end
   end

   // read data, reserved bits read zero
   always_comb
   begin
      hit   = 1'b1;
      rdata = 8'h00;
      if (req.addr == ADDR_CA)
         rdata = {comp_power_enable_q, result_q, rise_seen_flag_q, fall_seen_flag_q,
                  pos_hysteresis_sel_q, neg_hysteresis_sel_q};
      else if (req.addr == ADDR_MD)
         rdata = {overflow_latched_result_q, result_polarity_invert_q, rise_irq_enable_q,
                  fall_irq_enable_q, input_routing_sel_q, response_speed_sel_q};
      else if (req.addr == ADDR_MX)
         rdata = {neg_channel_sel_q, pos_channel_sel_q};
      else if (req.addr == ADDR_CB)
         rdata = {result_hold_enable_q, 1'b0, ref_dac_level_q};
      else
         hit = 1'b0;
   end
endmodule : dcc_channel
`default_nettype wire

/* File: dcc_top.sv */
`timescale 1ns/1ps
`default_nettype none
module dcc_top
   import dcc_pkg::*;
(
   input  wire logic         mclk,
   input  wire logic         rst_n,
   input  wire logic         sfr_wr,
   input  wire logic         sfr_rd,
   input  wire logic [7:0]   sfr_addr,
   input  wire logic [7:0]   sfr_wdata,
   output var  logic [7:0]   sfr_rdata,
   input  wire logic [1:0]   raw_result,
   input  wire logic         counter_overflow,
   input  wire logic         counter_channel2_output,
   output var  logic [1:0]   comp_result,
   output var  logic [1:0]   rise_irq,
   output var  logic [1:0]   fall_irq,
   output var  dcc_analog_t  analog0,
   output var  dcc_analog_t  analog1
);
   import dcc_pkg::*;

   dcc_sfr_req_t      req;
   logic [1:0]        hit;
   logic [1:0][7:0]   rdata;
   logic [1:0]        res;
   dcc_analog_t [1:0] analog_w;

   // per-channel addresses, channel 0 in the low entry
   localparam logic [1:0][7:0] ADDR_CA_TAB = {DCC_ADDR_C1_CTRL_A, DCC_ADDR_C0_CTRL_A};
   localparam logic [1:0][7:0] ADDR_CB_TAB = {DCC_ADDR_C1_CTRL_B, DCC_ADDR_C0_CTRL_B};
   localparam logic [1:0][7:0] ADDR_MD_TAB = {DCC_ADDR_C1_MODE, DCC_ADDR_C0_MODE};
   localparam logic [1:0][7:0] ADDR_MX_TAB = {DCC_ADDR_C1_INSEL, DCC_ADDR_C0_INSEL};

   assign req = '{wr: sfr_wr, rd: sfr_rd, addr: sfr_addr, wdata: sfr_wdata};

   // channels share only the register port, overflow and channel 2 inputs
   for (genvar ch = 0; ch < 2; ch++)
   begin : g_ch
      dcc_channel #(
         .ADDR_CA (ADDR_CA_TAB[ch]),
         .ADDR_CB (ADDR_CB_TAB[ch]),
         .ADDR_MD (ADDR_MD_TAB[ch]),
         .ADDR_MX (ADDR_MX_TAB[ch])
      ) u_ch (
         .mclk                    (mclk),
         .rst_n                   (rst_n),
         .req                     (req),
         .raw_result              (raw_result[ch]),
         .counter_overflow        (counter_overflow),
         .counter_channel2_output (counter_channel2_output),
         .hit                     (hit[ch]),
         .rdata                   (rdata[ch]),
         .result                  (res[ch]),
         .rise_irq                (rise_irq[ch]),
         .fall_irq                (fall_irq[ch]),
         .analog                  (analog_w[ch])
      );
   end

   // analog settings already leave each channel from flip-flops
   assign analog0 = analog_w[0];
   assign analog1 = analog_w[1];

   // registered read data, zero for unmapped or idle
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         sfr_rdata <= 8'h00;
      else if (sfr_rd && hit[0])
         sfr_rdata <= rdata[0];
      else if (sfr_rd && hit[1])
         sfr_rdata <= rdata[1];
      else
         sfr_rdata <= 8'h00;
   end

   // result already registered in channel; retimed for routed logic
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         comp_result <= 2'h0;
      else
         comp_result <= res;
   end
endmodule : dcc_top
`default_nettype wire

/* File: dcc_top_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// sees the top ports only; a register write reaches the analog bus two edges later
module dcc_top_chk
   import dcc_pkg::*;
(
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire logic        sfr_wr,
   input wire logic        sfr_rd,
   input wire logic [7:0]  sfr_addr,
   input wire logic [7:0]  sfr_wdata,
   input wire logic [7:0]  sfr_rdata,
   input wire logic [1:0]  raw_result,
   input wire logic        counter_overflow,
   input wire logic        counter_channel2_output,
   input wire logic [1:0]  comp_result,
   input wire logic [1:0]  rise_irq,
   input wire logic [1:0]  fall_irq,
   input wire dcc_analog_t analog0,
   input wire dcc_analog_t analog1
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   AST_STATE_BIT: assert property (
      sfr_rd && sfr_addr == 8'h9B |=> sfr_rdata[6] == comp_result[0])
      else $error("state bit differs from output");
   AST_RESV_ZERO: assert property (
      sfr_rd && (sfr_addr == 8'h99 || sfr_addr == 8'hAC) |=> !sfr_rdata[6])
      else $error("reserved bit reads one");
   // an interrupt may only drop because software wrote something
   AST_FLAG_STICKY: assert property (
      |($past(rise_irq) & ~rise_irq | $past(fall_irq) & ~fall_irq)
      |-> $past(sfr_wr) || $past(sfr_wr, 2))
      else $error("edge request dropped without a write");
   AST_HYST: assert property (
      sfr_wr && sfr_addr == 8'h9B |=> ##1
      {analog0.pos_hysteresis_sel, analog0.neg_hysteresis_sel} == $past(sfr_wdata[3:0], 2))
      else $error("hysteresis not passed to core");
   AST_ROUTE: assert property (
      sfr_wr && sfr_addr == 8'hAB |=> ##1
      {analog1.neg_to_gnd, analog1.dac_enable, analog1.response_speed_sel}
      == {$past(sfr_wdata[3:2], 2) == 2'h1, $past(sfr_wdata[3], 2), $past(sfr_wdata[1:0], 2)}
      && (!analog1.dac_enable || analog1.dac_on_pos == ($past(sfr_wdata[3:2], 2) == 2'h2)))
      else $error("routing or speed not passed to core");
   AST_MUX_SEL: assert property (
      sfr_wr && sfr_addr == 8'h9F |=> ##1
      {analog0.neg_channel_sel, analog0.pos_channel_sel} == $past(sfr_wdata, 2))
      else $error("mux selects not passed to core");
   AST_DAC_LVL: assert property (
      sfr_wr && sfr_addr == 8'h99 |=> ##1 analog0.ref_dac_level == $past(sfr_wdata[5:0], 2))
      else $error("dac level not passed to core");
   AST_OFF_LOW: assert property (
      sfr_wr && sfr_addr == 8'h9B && !sfr_wdata[7] |-> ##[1:4] !comp_result[0])
      else $error("disabled output not low");
   AST_RESET_SET: assert property (
      $rose(rst_n) |=> analog0.response_speed_sel == 2'h2 && analog0.ref_dac_level == 6'h00
      && {analog0.neg_channel_sel, analog0.pos_channel_sel} == 8'hFF)
      else $error("core settings wrong after reset");
   AST_SEPARATE: assert property (
      sfr_wr && sfr_addr inside {8'h9B, 8'h99, 8'h9D, 8'h9F} |=> ##1 $stable(analog1))
      else $error("channel 0 write moved channel 1");
endmodule : dcc_top_chk

bind dcc_top dcc_top_chk u_chk (.mclk(mclk), .rst_n(rst_n), .sfr_wr(sfr_wr),
   .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
   .raw_result(raw_result), .counter_overflow(counter_overflow),
   .counter_channel2_output(counter_channel2_output), .comp_result(comp_result),
   .rise_irq(rise_irq), .fall_irq(fall_irq), .analog0(analog0), .analog1(analog1));
`default_nettype wire

/* File: dcc_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
// two analog cores; vp and vn stand for the levels the muxes picked
module dcc_core_model
   import dcc_pkg::*;
(
   input  wire logic [1:0][7:0] vp,
   input  wire logic [1:0][7:0] vn,
   input  wire dcc_analog_t     analog0,
   input  wire dcc_analog_t     analog1,
   output var  logic [1:0]      raw_result
);
   function automatic logic decide(dcc_analog_t a, logic [7:0] p, logic [7:0] n);
      logic [13:0] dp;
      logic [13:0] dn;
      dp = (p * a.ref_dac_level) >> 6;
      dn = (n * a.ref_dac_level) >> 6;
      if (!a.power_enable)
         return 1'b0;
      if (a.dac_enable && a.dac_on_pos)
         return dp > {6'h00, n};
      if (a.dac_enable)
         return {6'h00, p} > dn;
      if (a.neg_to_gnd)
         return p > 8'h00;
      return p > n;
   endfunction : decide

   // no clock: the real cores answer asynchronously
   always_comb
   begin
      raw_result[0] = decide(analog0, vp[0], vn[0]);
      raw_result[1] = decide(analog1, vp[1], vn[1]);
   end
endmodule : dcc_core_model
`default_nettype wire

/* File: test_dual_comparator_control.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
   $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module test_dual_comparator_control;
   import dcc_pkg::*;
   typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} dcc_row_t;
   logic            mclk;
   logic            rst_n;
   logic            sfr_wr;
   logic            sfr_rd;
   logic [7:0]      sfr_addr;
   logic [7:0]      sfr_wdata;
   logic [7:0]      sfr_rdata;
   logic [1:0]      raw_result;
   logic            cnt_ovf;
   logic            cnt_ch2;
   logic [1:0]      comp_result;
   logic [1:0]      rise_irq;
   logic [1:0]      fall_irq;
   dcc_analog_t     analog0;
   dcc_analog_t     analog1;
   dcc_analog_t     ex;
   logic [1:0][7:0] vp;
   logic [1:0][7:0] vn;
   int              error_cnt = 0;
   int              checks_done = 0;
   // reset values, read-back, unmapped places; reserved bit only ever written 0, reads 0
   dcc_row_t rows [18] = '{
      {1'b0, 8'h9B, 8'h00, 8'h00}, {1'b0, 8'h99, 8'h00, 8'h00}, {1'b0, 8'h9D, 8'h00, 8'h02},
      {1'b0, 8'h9F, 8'h00, 8'hFF}, {1'b0, 8'hBF, 8'h00, 8'h00}, {1'b0, 8'hAC, 8'h00, 8'h00},
      {1'b0, 8'hAB, 8'h00, 8'h02}, {1'b0, 8'hAA, 8'h00, 8'hFF}, {1'b1, 8'h9D, 8'h0F, 8'h0F},
      {1'b1, 8'h9F, 8'h5A, 8'h5A}, {1'b1, 8'h99, 8'hBF, 8'hBF}, {1'b1, 8'h9B, 8'h0E, 8'h0E},
      {1'b1, 8'hAB, 8'h04, 8'h04}, {1'b1, 8'hAA, 8'hA5, 8'hA5}, {1'b1, 8'hAC, 8'h80, 8'h80},
      {1'b1, 8'hBF, 8'h07, 8'h07}, {1'b1, 8'h00, 8'hFF, 8'h00}, {1'b1, 8'h9E, 8'hFF, 8'h00}};

   dcc_top u_dut (.mclk(mclk), .rst_n(rst_n), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .raw_result(raw_result), .counter_overflow(cnt_ovf), .counter_channel2_output(cnt_ch2),
      .comp_result(comp_result), .rise_irq(rise_irq), .fall_irq(fall_irq),
      .analog0(analog0), .analog1(analog1));
   dcc_core_model u_core (.vp(vp), .vn(vn), .analog0(analog0), .analog1(analog1),
      .raw_result(raw_result));

   initial
   begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   task automatic conclude();
      if (error_cnt == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : conclude

   // strobe stands for exactly one edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      sfr_wr    <= 1'b1;
      sfr_addr  <= a;
      sfr_wdata <= d;
      @(posedge mclk);
      sfr_wr <= 1'b0;
   endtask : wr

   // read data is only valid in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk);
      sfr_rd   <= 1'b1;
      sfr_addr <= a;
      @(posedge mclk);
      sfr_rd <= 1'b0;
      #1;
      `CHK($sformatf("reg %h", a), e, sfr_rdata);
   endtask : rd

   task automatic pulse_ovf();
      @(posedge mclk);
      cnt_ovf <= 1'b1;
      @(posedge mclk);
      cnt_ovf <= 1'b0;
   endtask : pulse_ovf

   // bounded wait for the output, then room for flags and requests
   task automatic settle(input int ch, input logic e);
      int k;
      // look only where the output has settled after its edge
      #1;
      for (k = 0; k < 12 && comp_result[ch] !== e; k++)
      begin
         @(posedge mclk);
         #1;
      end
      `CHK("result", e, comp_result[ch]);
      if (k == 12)
         conclude();
      else
      begin
         repeat (3) @(posedge mclk);
         #1;
      end
   endtask : settle

   initial
   begin
      rst_n     = 1'b0;
      sfr_wr    = 1'b0;
      sfr_rd    = 1'b0;
      sfr_addr  = 8'h00;
      sfr_wdata = 8'h00;
      cnt_ovf   = 1'b0;
      cnt_ch2   = 1'b1;
      vp        = {8'h0A, 8'h0A};
      vn        = {8'h28, 8'h14};
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      foreach (rows[i])
      begin
         if (rows[i].w)
            wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].e);
      end
      ex = {1'b0, 2'h3, 2'h2, 2'h3, 8'hA5, 1'b0, 1'b1, 1'b0, 1'b1, 6'h3F};
      `CHK("analog0", ex, analog0);
      // every routing, hysteresis and speed code on channel 1
      for (int i = 0; i < 4; i++)
      begin
         wr(8'hAB, 8'(5 * i));
         wr(8'hBF, 8'(3 * i + 3));
         repeat (2) @(posedge mclk);
         #1;
         ex = {1'b0, 2'(i), 2'(3 - i), 2'(i), 8'h5A, i == 1, i[1], i == 2, i == 3, 6'h00};
         `CHK("analog1", ex, analog1);
      end
      // edge flags while masked, then unmasked
      wr(8'h9D, 8'h00);
      wr(8'h99, 8'h00);
      wr(8'h9B, 8'h80);
      vp[0] <= 8'h1E;
      settle(0, 1'b1);
      `CHK("rise_irq", 2'b00, rise_irq);
      rd(8'h9B, 8'hE0);
      wr(8'h9D, 8'h30);
      repeat (2) @(posedge mclk);
      #1;
      `CHK("rise_irq", 2'b01, rise_irq);
      vp[0] <= 8'h05;
      settle(0, 1'b0);
      rd(8'h9B, 8'hB0);
      `CHK("fall_irq", 2'b01, fall_irq);
      wr(8'h9B, 8'h80);
      rd(8'h9B, 8'h80);
      `CHK("irqs", 4'h0, {rise_irq, fall_irq});
      // inverted output drives flags and the overflow capture
      wr(8'h9D, 8'h70);
      settle(0, 1'b1);
      rd(8'h9B, 8'hE0);
      pulse_ovf();
      rd(8'h9D, 8'hF0);
      wr(8'h9D, 8'hB0);
      settle(0, 1'b0);
      rd(8'h9D, 8'hB0);
      pulse_ovf();
      rd(8'h9D, 8'h30);
      // output frozen while channel 2 is low
      wr(8'h99, 8'h80);
      cnt_ch2 <= 1'b0;
      vp[0]   <= 8'h1E;
      repeat (8) @(posedge mclk);
      #1;
      `CHK("held", 2'b00, comp_result);
      cnt_ch2 <= 1'b1;
      settle(0, 1'b1);
      wr(8'h9B, 8'h00);
      settle(0, 1'b0);
      // channel 1 with the dac on its negative input
      wr(8'hBF, 8'h80);
      settle(1, 1'b1);
      wr(8'hAC, 8'h3F);
      settle(1, 1'b0);
      rd(8'hBF, 8'hB0);
      `CHK("ch1 irq", 2'b00, {rise_irq[1], fall_irq[1]});
      // mid-run reset: outputs drop at once, registers return to reset values
      @(posedge mclk);
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      #1;
      `CHK("outs in reset", 6'h00, {comp_result, rise_irq, fall_irq});
      @(posedge mclk);
      rst_n <= 1'b1;
      rd(8'hBF, 8'h00);
      rd(8'hAB, 8'h02);
      rd(8'h9F, 8'hFF);
      conclude();
   end
endmodule : test_dual_comparator_control
`default_nettype wire
